// *** hdl/fsw_pkg.sv ***
// Package: constants and types for the FSK word serial interface
package fsw_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD = 1200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam int unsigned HYST_MS = 10;
  localparam int unsigned QUAL_MS = 5;
  localparam int unsigned HYST_CYC = CLK_HZ / 1000 * HYST_MS;
  localparam int unsigned QUAL_CYC = CLK_HZ / 1000 * QUAL_MS;
  localparam int CNT_W = 22;
  localparam int DATA_BITS = 8;
  localparam int SYNC_W = 5;
  localparam int SY_DEMOD = 0;
  localparam int SY_ENERGY = 1;
  localparam int SY_MODE = 2;
  localparam int SY_SLEEP = 3;
  localparam int SY_HCLK = 4;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam int CTRL_SLEEP = 0;
  localparam int ST_CAR_N = 0;
  localparam int ST_RDY_N = 1;
  localparam int ST_MODE = 2;
  localparam int ST_READS = 4;
  localparam int IRQ_W = 3;
  localparam int IRQ_WORD = 0;
  localparam int IRQ_CAR_ON = 1;
  localparam int IRQ_CAR_OFF = 2;
  localparam logic CTRL_RST = 1'h0;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } fsw_rx_t;
  typedef enum logic [1:0] {
    CAR_OFF = 2'h1,
    CAR_ON = 2'h2
  } fsw_car_t;
endpackage

// *** hdl/fsw_sync.sv ***
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module fsw_sync #(
  parameter int W = 1
) (
  input wire logic hclk,        // System clock
  input wire logic hresetn,     // Async reset, active low
  input wire logic [W-1:0] d,   // Asynchronous inputs
  output logic [W-1:0] q        // Synchronised outputs
);
  logic [W-1:0] meta;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// *** hdl/fsw_word_serial.sv ***
// FSK word framer with three-wire host interface and AHB-Lite registers
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
// How it works
// - Carrier flag open-drain in mode 0, push-pull mode 1
// - Carrier flag after qualify time, held through gaps
// - No words delivered without carrier
// - Sleep input idles receiver, carrier and ready; mode 1 host clocks still shift the buffer
// - Mode pin low selects 0, high selects 1
// - Shift clock driven in mode 0, input mode 1
// - Fixed 1200 baud, start, 8 data, stop
// - Mode 0 data pin follows demodulated bits
// - Mode 0 emits eight clock pulses per word
// - Rising clock edge at each data bit centre
// - No clock pulses on start or stop bits
// - One ready pulse per ten-bit frame
// - Mode 1 holds each byte in one buffer
// - Ready low half bit; idle hi-Z or high
// - First host clock edge ends ready pulse early
// - Mark is one, space is zero
module fsw_word_serial
  import fsw_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYC,
  parameter int unsigned HALF_CYCLES = HALF_CYC,
  parameter int unsigned QUAL_CYCLES = QUAL_CYC,
  parameter int unsigned HYST_CYCLES = HYST_CYC
) (
  input wire logic hclk,                 // Clock, 250 MHz
  input wire logic hresetn,              // Async reset, active low
  input wire logic hsel,                 // AHB slave select
  input wire logic [31:0] haddr,         // AHB address
  input wire logic [1:0] htrans,         // AHB transfer type
  input wire logic hwrite,               // AHB write
  input wire logic [2:0] hsize,          // AHB size, word only
  input wire logic [31:0] hwdata,        // AHB write data
  input wire logic hready,               // AHB bus ready
  output logic hreadyout,                // AHB slave ready
  output logic hresp,                    // AHB response
  output logic [31:0] hrdata,            // AHB read data
  input wire logic demod_bit,            // Demodulated bit, mark high
  input wire logic carrier_energy,       // Band energy present
  input wire logic mode_select,          // Interface mode pin
  input wire logic sleep_request,        // Power-down pin
  input wire logic bit_shift_clock_in,   // Shift clock pin level
  output logic bit_shift_clock_out,      // Shift clock drive value
  output logic bit_shift_clock_oe,       // Shift clock drive enable
  output logic fsk_data,                 // Serial data pin
  input wire logic word_ready_n_in,      // Ready pin level
  output logic word_ready_n_out,         // Ready drive value
  output logic word_ready_n_oe,          // Ready drive enable
  input wire logic carrier_present_n_in, // Carrier pin level
  output logic carrier_present_n_out,    // Carrier drive value
  output logic carrier_present_n_oe,     // Carrier drive enable
  output logic irq                       // Interrupt, active high
);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
  localparam logic [CNT_W-1:0] CLK_FALL =
    CNT_W'(BIT_CYCLES - 1 - HALF_CYCLES);
  localparam logic [CNT_W-1:0] QUAL_LAST = CNT_W'(QUAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] HYST_LAST = CNT_W'(HYST_CYCLES - 1);
  localparam logic [3:0] READS_FULL = 4'(DATA_BITS);
  localparam logic [2:0] LAST_IDX = 3'(DATA_BITS - 1);

  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] pins_s;
  logic rx_s, energy_s, mode_s, hclk_s, sleep;
  logic hc_d, host_rise;

  assign pins = {bit_shift_clock_in, sleep_request, mode_select,
    carrier_energy, demod_bit};

  fsw_sync #(.W(SYNC_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pins),
    .q(pins_s)
  );

  // Bus-side state
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic ctrl_sleep, next_ctrl_sleep;
  logic [IRQ_W-1:0] irq_en, next_irq_en, irq_stat, next_irq_stat;
  logic [IRQ_W-1:0] irq_clr, events;
  // Carrier state
  fsw_car_t car_st, next_car_st;
  logic [CNT_W-1:0] car_cnt, next_car_cnt;
  logic car_n;
  // Receiver and host-side state
  fsw_rx_t rx_st, next_rx_st;
  logic [CNT_W-1:0] rx_cnt, next_rx_cnt, rdy_cnt, next_rdy_cnt;
  logic [2:0] bit_idx, next_bit_idx;
  logic [7:0] rx_shift, next_rx_shift, rx_byte, next_rx_byte;
  logic [7:0] out_shift, next_out_shift;
  logic [3:0] reads_left, next_reads_left;
  logic prev_rx, sclk_q, next_sclk, rdy_n, next_rdy_n;
  logic data_q, next_data;
  logic word_done;

  assign rx_s = pins_s[SY_DEMOD];
  assign energy_s = pins_s[SY_ENERGY];
  assign mode_s = pins_s[SY_MODE];
  assign hclk_s = pins_s[SY_HCLK];
  assign sleep = pins_s[SY_SLEEP] | ctrl_sleep;
  assign host_rise = hclk_s & ~hc_d;
  assign car_n = (car_st != CAR_ON);

  // Zero wait states, always OKAY; only word accesses are meaningful
  wire bus_acc = hsel & htrans[1] & hready;
  assign hreadyout = 1'h1;
  assign hresp = 1'h0;

  always_comb begin
    next_wr_pend = bus_acc & hwrite;
    next_wr_addr = bus_acc ? haddr[7:0] : wr_addr;
    next_hrdata = hrdata;
    if (bus_acc && !hwrite) begin
      case (haddr[7:0])
        OFS_CTRL: next_hrdata = {31'h0, ctrl_sleep};
        OFS_STATUS: next_hrdata = {24'h0, reads_left, 1'h0, mode_s,
          rdy_n, car_n};
        OFS_RXDATA: next_hrdata = {24'h0, rx_byte};
        OFS_IRQ_STAT: next_hrdata = {29'h0, irq_stat};
        OFS_IRQ_EN: next_hrdata = {29'h0, irq_en};
        default: next_hrdata = 32'h0;
      endcase
    end
    next_ctrl_sleep = ctrl_sleep;
    next_irq_en = irq_en;
    irq_clr = '0;
    if (wr_pend) begin
      case (wr_addr)
        OFS_CTRL: next_ctrl_sleep = hwdata[CTRL_SLEEP];
        OFS_IRQ_EN: next_irq_en = hwdata[IRQ_W-1:0];
        OFS_IRQ_CLR: irq_clr = hwdata[IRQ_W-1:0];
        default: next_ctrl_sleep = ctrl_sleep;
      endcase
    end
    // A new event in the clearing cycle stays set
    next_irq_stat = (irq_stat & ~irq_clr) | events;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'h0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0;
      ctrl_sleep <= CTRL_RST;
      irq_en <= IRQ_EN_RST;
      irq_stat <= '0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      ctrl_sleep <= next_ctrl_sleep;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
    end
  end

  assign irq = |(irq_stat & irq_en);
  assign events[IRQ_WORD] = word_done;
  assign events[IRQ_CAR_ON] = (car_st == CAR_OFF) && (next_car_st == CAR_ON);
  assign events[IRQ_CAR_OFF] = (car_st == CAR_ON) && (next_car_st == CAR_OFF);

  // Carrier qualifier: energy must persist, then gaps are bridged
  always_comb begin
    next_car_st = car_st;
    next_car_cnt = car_cnt;
    case (car_st)
      CAR_OFF: begin
        if (!energy_s) begin
          next_car_cnt = '0;
        end else if (car_cnt == QUAL_LAST) begin
          next_car_st = CAR_ON;
          next_car_cnt = '0;
        end else begin
          next_car_cnt = car_cnt + 1'h1;
        end
      end
      CAR_ON: begin
        if (energy_s) begin
          next_car_cnt = '0;
        end else if (car_cnt == HYST_LAST) begin
          next_car_st = CAR_OFF;
          next_car_cnt = '0;
        end else begin
          next_car_cnt = car_cnt + 1'h1;
        end
      end
      default: begin
        next_car_st = CAR_OFF;
        next_car_cnt = '0;
      end
    endcase
    if (sleep) begin
      next_car_st = CAR_OFF;
      next_car_cnt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      car_st <= CAR_OFF;
      car_cnt <= '0;
    end else begin
      car_st <= next_car_st;
      car_cnt <= next_car_cnt;
    end
  end

  // Frame timing counts down from each start edge, so drift never builds
  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = (rx_cnt == '0) ? '0 : rx_cnt - 1'h1;
    next_bit_idx = bit_idx;
    next_rx_shift = rx_shift;
    next_rx_byte = rx_byte;
    next_out_shift = out_shift;
    next_reads_left = reads_left;
    next_sclk = (sclk_q && rx_cnt == CLK_FALL) ? 1'h0 : sclk_q;
    next_rdy_n = rdy_n;
    next_rdy_cnt = (rdy_cnt == '0) ? '0 : rdy_cnt - 1'h1;
    next_data = data_q;
    word_done = 1'h0;
    case (rx_st)
      RX_IDLE: begin
        if (!car_n && prev_rx && !rx_s) begin
          next_rx_st = RX_START;
          next_rx_cnt = HALF_LAST;
        end
      end
      RX_START: begin
        if (rx_cnt == '0) begin
          next_rx_st = rx_s ? RX_IDLE : RX_DATA;
          next_rx_cnt = BIT_LAST;
          next_bit_idx = 3'h0;
        end
      end
      RX_DATA: begin
        if (rx_cnt == '0) begin
          next_rx_shift = {rx_s, rx_shift[7:1]};
          next_sclk = ~mode_s;
          next_rx_cnt = BIT_LAST;
          next_bit_idx = bit_idx + 1'h1;
          if (bit_idx == LAST_IDX) begin
            next_rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt == '0) begin
          next_rx_st = RX_IDLE;
          word_done = 1'h1;
          next_rx_byte = rx_shift;
          next_rdy_n = 1'h0;
          next_rdy_cnt = HALF_LAST;
          if (mode_s) begin
            next_out_shift = rx_shift;
            next_reads_left = READS_FULL;
          end
        end
      end
      default: next_rx_st = RX_IDLE;
    endcase
    if (!rdy_n && rdy_cnt == '0) begin
      next_rdy_n = 1'h1;
    end
    if (mode_s && host_rise) begin
      next_rdy_n = 1'h1;
      if (reads_left != 4'h0) begin
        next_data = out_shift[0];
        next_out_shift = {1'h0, out_shift[7:1]};
        next_reads_left = reads_left - 1'h1;
      end
    end
    if (!mode_s) begin
      next_data = car_n ? 1'h1 : rx_s;
    end
    if (car_n && rx_st != RX_IDLE) begin
      next_rx_st = RX_IDLE;
      next_sclk = 1'h0;
    end
    if (sleep) begin
      next_rx_st = RX_IDLE;
      next_rx_cnt = '0;
      next_sclk = ~mode_s;
      next_rdy_n = 1'h1;
      next_data = mode_s ? data_q : 1'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st <= RX_IDLE;
      rx_cnt <= '0;
      bit_idx <= 3'h0;
      rx_shift <= 8'h00;
      rx_byte <= 8'h00;
      out_shift <= 8'h00;
      reads_left <= 4'h0;
      prev_rx <= 1'h1;
      hc_d <= 1'h0;
      sclk_q <= 1'h0;
      rdy_n <= 1'h1;
      rdy_cnt <= '0;
      data_q <= 1'h1;
    end else begin
      rx_st <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      bit_idx <= next_bit_idx;
      rx_shift <= next_rx_shift;
      rx_byte <= next_rx_byte;
      out_shift <= next_out_shift;
      reads_left <= next_reads_left;
      prev_rx <= rx_s;
      hc_d <= hclk_s;
      sclk_q <= next_sclk;
      rdy_n <= next_rdy_n;
      rdy_cnt <= next_rdy_cnt;
      data_q <= next_data;
    end
  end

  // Open drain in mode 0 only ever pulls low
  assign carrier_present_n_out = mode_s ? car_n : 1'h0;
  assign carrier_present_n_oe = mode_s | ~car_n;
  assign word_ready_n_out = mode_s ? rdy_n : 1'h0;
  assign word_ready_n_oe = mode_s | ~rdy_n;
  assign bit_shift_clock_out = sclk_q;
  assign bit_shift_clock_oe = ~mode_s;
  assign fsk_data = data_q;

  // Checks
  logic [3:0] burst_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_cnt <= 4'h0;
    end else if (rx_st == RX_IDLE) begin
      burst_cnt <= 4'h0;
    end else if (sclk_q && !$past(sclk_q)) begin
      burst_cnt <= burst_cnt + 1'h1;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_CAR_OPEN_DRAIN: assert property (
    !mode_s |-> !carrier_present_n_out && (carrier_present_n_oe == !car_n))
    else $error("carrier flag not open drain in mode 0");
  AST_CAR_PUSH_PULL: assert property (
    mode_s |-> carrier_present_n_oe && (carrier_present_n_out == car_n))
    else $error("carrier flag not driven in mode 1");
  AST_CAR_QUAL: assert property (
    $fell(car_n) |-> $past(energy_s) && $past(car_cnt) == QUAL_LAST)
    else $error("carrier flagged before qualify time");
  AST_NO_WORD_NO_CAR: assert property (
    (car_n && rx_st == RX_IDLE) |=> rdy_n || $past(!rdy_n))
    else $error("word delivered without carrier");
  AST_SLEEP_QUIET: assert property (
    sleep |=> rx_st == RX_IDLE && rdy_n && car_n)
    else $error("activity while sleeping");
  AST_CLK_DIR: assert property (
    bit_shift_clock_oe != mode_s)
    else $error("shift clock direction wrong");
  AST_DATA_PASS: assert property (
    (!mode_s && !sleep && !car_n) ##1 !mode_s |-> fsk_data == $past(rx_s))
    else $error("mode 0 data does not follow demodulator");
  AST_CLK_CENTRE: assert property (
    $rose(sclk_q) && !$past(sleep) |-> $past(rx_st) == RX_DATA &&
      $past(rx_cnt) == '0)
    else $error("shift clock rise off bit centre");
  AST_BURST_8: assert property (
    (!mode_s && $rose(rx_st == RX_STOP)) ##1 !mode_s [*2] |->
      burst_cnt == 4'h8)
    else $error("burst is not eight pulses");
  AST_READY_FRAME: assert property (
    $fell(rdy_n) |-> $past(rx_st) == RX_STOP && irq_stat[IRQ_WORD])
    else $error("ready pulse without a frame");
  AST_EARLY_CLEAR: assert property (
    (mode_s && !rdy_n && host_rise && !sleep) |=> rdy_n)
    else $error("host clock did not end ready pulse");
  AST_SHIFT_OUT: assert property (
    (mode_s && host_rise && reads_left != 4'h0 && !sleep) |=>
      fsk_data == $past(out_shift[0]) &&
      reads_left == $past(reads_left) - 4'h1)
    else $error("buffered byte not shifted out");

  COV_WORD_M0: cover property (!mode_s && word_done);
  COV_WORD_M1_READ: cover property (mode_s && !rdy_n ##1 host_rise);
  COV_CAR_LOST: cover property (events[IRQ_CAR_OFF]);
  COV_IRQ: cover property ($rose(irq));
endmodule

// *** testbench/fsw_host_model.sv ***
// Host model: shift register in mode 0, shift clock master in mode 1
`timescale 1ns/100ps
module fsw_host_model (
  input wire logic mode_select, // Interface mode level
  input wire logic shift_pin,   // Resolved shift clock pin
  input wire logic data_pin,    // Serial data pin
  output logic host_clk,        // Host drive of the shift clock
  output logic [7:0] rx_byte,   // Byte shifted in, first bit ends at bit 0
  output int unsigned edges     // Rising shift clock edges seen
);
  initial begin
    host_clk = 1'b0;
    rx_byte = 8'h00;
    edges = 0;
  end
  // Mode 0: data is taken on the rising edge, as a shift register would
  always @(posedge shift_pin) begin
    edges <= edges + 1;
    if (!mode_select) begin
      rx_byte <= {data_pin, rx_byte[7:1]};
    end
  end
  // Clock stands still between calls; data taken in the low phase
  task automatic read_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      host_clk = 1'b1;
      #80;
      host_clk = 1'b0;
      #40;
      rx_byte = {data_pin, rx_byte[7:1]};
      #40;
    end
  endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the FSK word serial interface
`timescale 1ns/100ps
module testbench;
  import fsw_pkg::*;
  localparam int BITC = 200;
  localparam int HALFC = 100;
  localparam int QUALC = 300;
  localparam int HYSTC = 2000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, fsk_data;
  logic [31:0] hrdata;
  logic demod = 1'b1;
  logic energy = 1'b0;
  logic mode = 1'b0;
  logic sleep = 1'b0;
  logic sc_out, sc_oe, wr_out, wr_oe, cp_out, cp_oe, host_clk;
  logic [7:0] host_byte;
  int unsigned edges;
  wire logic shift_pin = sc_oe ? sc_out : host_clk;
  // Open-drain pins float to the pull-up when released
  wire logic ready_pin = wr_oe ? wr_out : 1'b1;
  wire logic carrier_pin = cp_oe ? cp_out : 1'b1;
  int miscompares = 0;
  int tests_run = 0;
  int falls = 0;
  int low_cyc = 0;
  logic rdy_q = 1'b1;
  logic [31:0] d;

  fsw_word_serial #(.BIT_CYCLES(BITC), .HALF_CYCLES(HALFC),
    .QUAL_CYCLES(QUALC), .HYST_CYCLES(HYSTC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .demod_bit(demod), .carrier_energy(energy),
    .mode_select(mode), .sleep_request(sleep),
    .bit_shift_clock_in(shift_pin), .bit_shift_clock_out(sc_out),
    .bit_shift_clock_oe(sc_oe), .fsk_data(fsk_data),
    .word_ready_n_in(ready_pin), .word_ready_n_out(wr_out),
    .word_ready_n_oe(wr_oe), .carrier_present_n_in(carrier_pin),
    .carrier_present_n_out(cp_out), .carrier_present_n_oe(cp_oe),
    .irq(irq));

  fsw_host_model host (.mode_select(mode), .shift_pin(shift_pin),
    .data_pin(fsk_data), .host_clk(host_clk), .rx_byte(host_byte),
    .edges(edges));

  initial begin
    forever #2 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    rdy_q <= ready_pin;
    if (rdy_q && !ready_pin) falls++;
    if (!ready_pin) low_cyc++;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Single AHB-Lite transfer; the wait has no bound but the watchdog
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] rd);
    ahb(1'b0, a, 32'h0, rd);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    ahb(1'b1, a, wd, dummy);
    repeat (2) @(posedge hclk);
  endtask

  // Start, eight data bits first bit first, stop: one ten-bit frame
  task automatic send_frame(input logic [7:0] b);
    @(posedge hclk);
    demod <= 1'b0;
    repeat (BITC) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      demod <= b[i];
      repeat (BITC) @(posedge hclk);
    end
    demod <= 1'b1;
    repeat (BITC) @(posedge hclk);
  endtask

  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    int e0;
    int f0;
    int l0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    reg_rd(OFS_CTRL, d); check(d, 32'h0, "ctrl reset");
    reg_rd(OFS_IRQ_EN, d); check(d, 32'h0, "irq enable reset");
    reg_wr(8'h40, 32'hFFFFFFFF);
    reg_rd(8'h40, d); check(d, 32'h0, "unmapped read");
    check(hresp, 1'b0, "okay response");
    check(ready_pin, 1'b1, "ready at rest mode 0");
    check(carrier_pin, 1'b1, "carrier at rest");
    // Frame with no carrier must vanish
    e0 = edges;
    f0 = falls;
    send_frame(8'h5A);
    repeat (HALFC + 20) @(posedge hclk);
    check(edges - e0, 0, "clock without carrier");
    check(falls - f0, 0, "ready without carrier");
    check(fsk_data, 1'b1, "data forced high");
    reg_rd(OFS_RXDATA, d); check(d, 32'h0, "rxdata untouched");
    energy <= 1'b1;
    repeat (QUALC / 2) @(posedge hclk);
    check(carrier_pin, 1'b1, "carrier too early");
    repeat (QUALC / 2 + 20) @(posedge hclk);
    check(carrier_pin, 1'b0, "carrier qualified");
    check({cp_oe, cp_out}, 2'b10, "open drain carrier");
    // A short gap must not drop the carrier flag
    energy <= 1'b0;
    repeat (500) @(posedge hclk);
    energy <= 1'b1;
    repeat (10) @(posedge hclk);
    check(carrier_pin, 1'b0, "carrier through gap");
    e0 = edges;
    f0 = falls;
    l0 = low_cyc;
    send_frame(8'hA5);
    repeat (HALFC + 20) @(posedge hclk);
    check(edges - e0, 8, "mode 0 pulse count");
    check(host_byte, 8'hA5, "mode 0 byte");
    check(falls - f0, 1, "one ready per frame");
    check(low_cyc - l0 >= HALFC - 5 && low_cyc - l0 <= HALFC + 5, 1,
          "ready width");
    reg_rd(OFS_RXDATA, d); check(d, 32'hA5, "rxdata");
    reg_rd(OFS_IRQ_STAT, d); check(d, 32'h3, "status word and gain");
    reg_wr(OFS_IRQ_EN, 32'h1);
    check(irq, 1'b1, "irq raised");
    reg_wr(OFS_IRQ_EN, 32'h0);
    check(irq, 1'b0, "irq masked");
    reg_wr(OFS_IRQ_EN, 32'h7);
    reg_wr(OFS_IRQ_CLR, 32'h3);
    reg_rd(OFS_IRQ_STAT, d); check(d, 32'h0, "status cleared");
    check(irq, 1'b0, "irq cleared");
    reg_rd(OFS_IRQ_CLR, d); check(d, 32'h0, "clear reads zero");
    mode <= 1'b1;
    repeat (10) @(posedge hclk);
    check(sc_oe, 1'b0, "shift clock is input");
    check({wr_oe, ready_pin}, 2'b11, "ready driven high");
    check(cp_oe, 1'b1, "carrier push-pull");
    reg_rd(OFS_STATUS, d); check(d[ST_MODE], 1'b1, "mode status");
    l0 = low_cyc;
    fork
      send_frame(8'h3C);
      begin
        @(negedge ready_pin);
        host.read_pulses(1);
      end
    join
    check(low_cyc - l0 < 30, 1, "ready cut by host clock");
    host.read_pulses(7);
    check(host_byte, 8'h3C, "mode 1 byte");
    reg_rd(OFS_STATUS, d); check(d, 32'h6, "status after reads");
    energy <= 1'b0;
    repeat (HYSTC - 100) @(posedge hclk);
    check(carrier_pin, 1'b0, "carrier held");
    repeat (200) @(posedge hclk);
    check(carrier_pin, 1'b1, "carrier released");
    reg_rd(OFS_IRQ_STAT, d); check(d, 32'h5, "status word and loss");
    check(irq, 1'b1, "irq on loss");
    mode <= 1'b0;
    sleep <= 1'b1;
    repeat (10) @(posedge hclk);
    check({fsk_data, sc_out, ready_pin}, 3'h7, "sleep levels");
    sleep <= 1'b0;
    reg_wr(OFS_CTRL, 32'h1);
    reg_rd(OFS_CTRL, d); check(d, 32'h1, "soft sleep");
    check({fsk_data, sc_out}, 2'h3, "soft sleep levels");
    tally_and_finish();
  end
endmodule
